/* File: tcm_defines.vh */
`ifndef TCM_DEFINES_VH
`define TCM_DEFINES_VH
// ==========================================================
// register byte addresses
`define TCM_ADDR_CTRL2     8'h00
`define TCM_ADDR_BUF       8'h04
`define TCM_ADDR_BAUD      8'h08
`define TCM_ADDR_STATUS    8'h0C
`define TCM_ADDR_IRQ_STAT  8'h10
`define TCM_ADDR_IRQ_MASK  8'h14
`define TCM_ADDR_MODE      8'h18
// ==========================================================
// control two field positions
`define TCM_B_GENERAL_CALL_ENABLE_EN      7
`define TCM_B_ACK_STATUS_FLAG      6
`define TCM_B_ACK_DATA_VALUE        5
`define TCM_B_ACKSEQ       4
`define TCM_B_RECV         3
`define TCM_B_STOP         2
`define TCM_B_RSTART       1
`define TCM_B_START        0
`define TCM_CTRL2_RESET    8'h00
`define TCM_BAUD_RESET     7'h04
// ==========================================================
// interrupt bits
`define TCM_IRQ_GCALL      0
`define TCM_IRQ_BCOL       1
`define TCM_IRQ_DONE       2
// ==========================================================
// mode register bits
`define TCM_MODE_SLAVE     0
`define TCM_MODE_MRX       1
`define TCM_SYNC_STAGES    3
`endif

/* File: tcm_sync.v */
`timescale 1ns/1ps
// ==========================================================
// three-stage pin synchroniser; output changes when stages two and three agree
module tcm_sync (
  input  wire clock_in,  // system clock
  input  wire rstn_in,   // async reset, active low
  input  wire pin_in,    // raw pin level
  output reg  level_out  // filtered level
);
  reg s1;
  reg s2;
  reg s3;
  // s1 feeds only s2; the idle bus is high so reset to one
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1        <= 1'b1;
      s2        <= 1'b1;
      s3        <= 1'b1;
      level_out <= 1'b1;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_out <= s3;
      end
    end
  end
endmodule // tcm_sync

/* File: tcm_ctrl.v */
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "tcm_defines.vh"
// Operation
// - the ack, receive, stop, repeated start and start requests are refused while the port is busy.
// - writes to the transfer buffer are ignored while the port is busy.
// - a Stop drives SDA low, then releases SCL and waits until SCL reads high.
// - after SCL reads high in a Stop, the baud counter loads the seven-bit reload and counts to zero.
// - SDA found low when the counter expires after its release is a bus collision.
// - SCL found low after it reads high and before the counter expires after SDA release is a bus collision.
module tcm_ctrl (
  input  wire       clock_in,     // 250 MHz system clock
  input  wire       rstn_in,      // async reset, active low
  input  wire       wb_cyc_in,    // wishbone cycle
  input  wire       wb_stb_in,    // wishbone strobe
  input  wire       wb_we_in,     // wishbone write
  input  wire [7:0] wb_adr_in,    // wishbone byte address
  input  wire [3:0] wb_sel_in,    // wishbone byte lanes
  input  wire [31:0] wb_dat_in,   // wishbone write data
  output reg  [31:0] wb_dat_out,  // wishbone read data
  output reg        wb_ack_out,   // wishbone acknowledge
  input  wire       scl_in,       // clock line level
  output wire       scl_out,      // clock line drive value
  output wire       scl_oe_out,   // high while pulling clock low
  input  wire       sda_in,       // data line level
  output wire       sda_out,      // data line drive value
  output wire       sda_oe_out,   // high while pulling data low
  output wire       irq_out       // level interrupt
);
  // ==========================================================
  // states
  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_P_LOW  = 4'h1;
  localparam [3:0] ST_P_SCL  = 4'h2;
  localparam [3:0] ST_P_WAIT = 4'h3;
  localparam [3:0] ST_P_REL  = 4'h4;
  localparam [3:0] ST_A_LO   = 4'h5;
  localparam [3:0] ST_A_HI   = 4'h6;
  localparam [3:0] ST_S_HI   = 4'h7;
  localparam [3:0] ST_S_LOW  = 4'h8;
  localparam [3:0] ST_BIT_LO = 4'h9;
  localparam [3:0] ST_BIT_HI = 4'hA;

  reg  [3:0] state;
  reg  [7:0] ctrl2;
  reg  [7:0] xfer_buf;
  reg  [7:0] shift_reg;
  reg  [6:0] baud_reload_value;
  reg  [6:0] baud_rate_counter;
  reg  [3:0] bit_cnt;
  reg  [1:0] mode;
  reg  [2:0] irq_stat;
  reg  [2:0] irq_mask;
  reg        sda_drive_low;
  reg        scl_drive_low;
  reg        scl_hi_prev;
  reg        tx_byte;
  wire       scl_lvl;
  wire       sda_lvl;
  wire       idle;
  wire       brg_zero;
  wire       bus_req;
  wire       wr_cycle;
  wire [2:0] ev;
  reg  [2:0] next_ev;

  // ==========================================================
  // pin synchronisers
  tcm_sync u_scl (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .pin_in   (scl_in),
    .level_out(scl_lvl)
  );
  tcm_sync u_sda (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .pin_in   (sda_in),
    .level_out(sda_lvl)
  );

  // open-drain outputs only ever pull low
  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign scl_oe_out = scl_drive_low;
  assign sda_oe_out = sda_drive_low;
  assign idle       = (state == ST_IDLE);
  assign brg_zero   = (baud_rate_counter == 7'h00);
  assign bus_req    = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_cycle   = bus_req && wb_we_in && wb_sel_in[0];
  assign ev         = next_ev;
  assign irq_out    = |(irq_stat & irq_mask);

  // ==========================================================
  // wishbone slave: one wait state, unmapped reads return zero
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= bus_req;
      if (bus_req && !wb_we_in) begin
        case (wb_adr_in)
          `TCM_ADDR_CTRL2:    wb_dat_out <= {24'h000000, ctrl2};
          `TCM_ADDR_BUF:      wb_dat_out <= {24'h000000, xfer_buf};
          `TCM_ADDR_BAUD:     wb_dat_out <= {25'h0000000, baud_reload_value};
          `TCM_ADDR_STATUS:   wb_dat_out <= {27'h0000000, !idle, state};
          `TCM_ADDR_IRQ_STAT: wb_dat_out <= {29'h00000000, irq_stat};
          `TCM_ADDR_IRQ_MASK: wb_dat_out <= {29'h00000000, irq_mask};
          `TCM_ADDR_MODE:     wb_dat_out <= {30'h00000000, mode};
          default:            wb_dat_out <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // sticky interrupt status; a new event beats a same-cycle clear
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
    end else begin
      if (wr_cycle && wb_adr_in == `TCM_ADDR_IRQ_MASK) begin
        irq_mask <= wb_dat_in[2:0];
      end
      if (wr_cycle && wb_adr_in == `TCM_ADDR_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~wb_dat_in[2:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
    end
  end

  // ==========================================================
  // event decode from the sequencer
  always @* begin
    next_ev = 3'h0;
    if (state == ST_BIT_LO && scl_lvl && !scl_hi_prev && bit_cnt == 4'h8 && !tx_byte &&
        mode[`TCM_MODE_SLAVE] && ctrl2[`TCM_B_GENERAL_CALL_ENABLE_EN] && shift_reg == 8'h00) begin
      next_ev[`TCM_IRQ_GCALL] = 1'b1;
    end
    if ((state == ST_P_WAIT || state == ST_P_REL) && !scl_lvl) begin
      next_ev[`TCM_IRQ_BCOL] = 1'b1;
    end
    if (state == ST_P_REL && brg_zero && !sda_lvl) begin
      next_ev[`TCM_IRQ_BCOL] = 1'b1;
    end
    if (state == ST_P_REL && brg_zero && sda_lvl) begin
      next_ev[`TCM_IRQ_DONE] = 1'b1;
    end
    if (state == ST_A_HI && brg_zero) begin
      next_ev[`TCM_IRQ_DONE] = 1'b1;
    end
  end

  // ==========================================================
  // control registers and line sequencer
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state             <= ST_IDLE;
      ctrl2             <= `TCM_CTRL2_RESET;
      xfer_buf          <= 8'h00;
      shift_reg         <= 8'h00;
      baud_reload_value <= `TCM_BAUD_RESET;
      baud_rate_counter <= 7'h00;
      bit_cnt           <= 4'h0;
      mode              <= 2'h0;
      sda_drive_low     <= 1'b0;
      scl_drive_low     <= 1'b0;
      scl_hi_prev       <= 1'b1;
      tx_byte           <= 1'b0;
    end else begin
      scl_hi_prev <= scl_lvl;
      if (!brg_zero) begin
        baud_rate_counter <= baud_rate_counter - 7'h01;
      end
      // software writes; request bits only taken when idle
      if (wr_cycle && wb_adr_in == `TCM_ADDR_CTRL2) begin
        ctrl2[`TCM_B_GENERAL_CALL_ENABLE_EN] <= wb_dat_in[`TCM_B_GENERAL_CALL_ENABLE_EN];
        ctrl2[`TCM_B_ACK_DATA_VALUE]   <= wb_dat_in[`TCM_B_ACK_DATA_VALUE];
        if (idle) begin
          ctrl2[4:0] <= wb_dat_in[4:0];
        end
      end
      if (wr_cycle && wb_adr_in == `TCM_ADDR_BUF && idle) begin
        xfer_buf  <= wb_dat_in[7:0];
        shift_reg <= wb_dat_in[7:0];
      end
      if (wr_cycle && wb_adr_in == `TCM_ADDR_BAUD) begin
        baud_reload_value <= wb_dat_in[6:0];
      end
      if (wr_cycle && wb_adr_in == `TCM_ADDR_MODE) begin
        mode <= wb_dat_in[1:0];
      end
      case (state)
        ST_IDLE: begin
          sda_drive_low <= 1'b0;
          scl_drive_low <= 1'b0;
          if (ctrl2[`TCM_B_STOP]) begin
            sda_drive_low <= 1'b1;
            scl_drive_low <= 1'b1;
            state         <= ST_P_LOW;
          end else if (ctrl2[`TCM_B_ACKSEQ] && mode[`TCM_MODE_MRX]) begin
            sda_drive_low     <= !ctrl2[`TCM_B_ACK_DATA_VALUE];
            scl_drive_low     <= 1'b1;
            baud_rate_counter <= baud_reload_value;
            state             <= ST_A_LO;
          end else if (ctrl2[`TCM_B_START] || ctrl2[`TCM_B_RSTART]) begin
            baud_rate_counter <= baud_reload_value;
            state             <= ST_S_HI;
          end else if (ctrl2[`TCM_B_RECV] || (!mode[`TCM_MODE_SLAVE] && 1'b0)) begin
            tx_byte <= 1'b0;
            bit_cnt <= 4'h0;
            state   <= ST_BIT_LO;
          end else if (mode[`TCM_MODE_SLAVE] && !scl_lvl) begin
            tx_byte <= 1'b0;
            bit_cnt <= 4'h0;
            state   <= ST_BIT_LO;
          end
        end
        ST_P_LOW: begin
          if (!sda_lvl) begin
            scl_drive_low <= 1'b0;
            state         <= ST_P_SCL;
          end
        end
        ST_P_SCL: begin
          // waiting here honours clock stretching by other parties
          if (scl_lvl) begin
            baud_rate_counter <= baud_reload_value;
            state             <= ST_P_WAIT;
          end
        end
        ST_P_WAIT: begin
          if (!scl_lvl) begin
            sda_drive_low      <= 1'b0;
            ctrl2[`TCM_B_STOP] <= 1'b0;
            state              <= ST_IDLE;
          end else if (brg_zero) begin
            sda_drive_low     <= 1'b0;
            baud_rate_counter <= baud_reload_value;
            state             <= ST_P_REL;
          end
        end
        ST_P_REL: begin
          // any collision or a clean end releases both lines
          if (!scl_lvl || brg_zero) begin
            ctrl2[`TCM_B_STOP] <= 1'b0;
            state              <= ST_IDLE;
          end
        end
        ST_A_LO: begin
          if (brg_zero) begin
            scl_drive_low     <= 1'b0;
            baud_rate_counter <= baud_reload_value;
            state             <= ST_A_HI;
          end
        end
        ST_A_HI: begin
          if (brg_zero) begin
            sda_drive_low        <= 1'b0;
            ctrl2[`TCM_B_ACKSEQ] <= 1'b0;
            state                <= ST_IDLE;
          end
        end
        ST_S_HI: begin
          if (brg_zero) begin
            sda_drive_low     <= 1'b1;
            baud_rate_counter <= baud_reload_value;
            state             <= ST_S_LOW;
          end
        end
        ST_S_LOW: begin
          if (brg_zero) begin
            ctrl2[1:0] <= 2'h0;
            tx_byte    <= !mode[`TCM_MODE_SLAVE];
            bit_cnt    <= 4'h0;
            state      <= ST_BIT_LO;
          end
        end
        ST_BIT_LO: begin
          // master drives the clock low in transmit; receive follows the bus
          scl_drive_low <= tx_byte && !brg_zero;
          sda_drive_low <= tx_byte && bit_cnt < 4'h8 && !shift_reg[7];
          if (tx_byte && baud_rate_counter == 7'h00 && scl_drive_low == 1'b0 &&
              scl_hi_prev == 1'b0) begin
            baud_rate_counter <= baud_reload_value;
          end
          // sample on the rising clock edge itself; the high state only waits for the fall
          if (scl_lvl && !scl_hi_prev) begin
            if (bit_cnt < 4'h8) begin
              shift_reg <= {shift_reg[6:0], tx_byte ? 1'b0 : sda_lvl};
            end else if (tx_byte) begin
              ctrl2[`TCM_B_ACK_STATUS_FLAG] <= sda_lvl;
            end
            state <= ST_BIT_HI;
          end else if (tx_byte && scl_drive_low && brg_zero) begin
            scl_drive_low <= 1'b0;
          end
        end
        ST_BIT_HI: begin
          if (!scl_lvl) begin
            if (bit_cnt == 4'h8) begin
              xfer_buf            <= shift_reg;
              sda_drive_low       <= 1'b0;
              ctrl2[`TCM_B_RECV]  <= 1'b0;
              state               <= ST_IDLE;
            end else begin
              bit_cnt           <= bit_cnt + 4'h1;
              baud_rate_counter <= baud_reload_value;
              state             <= ST_BIT_LO;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // tcm_ctrl

/* File: tcm_bus_peer.sv */
`timescale 1ns/1ps
// ==========================================================
// other masters and slaves on the shared pair
module tcm_bus_peer (
  input  wire       link_clk_in,  // peer timing clock
  input  wire       scl_oe_in,    // dut pulls clock low
  input  wire       sda_oe_in,    // dut pulls data low
  input  wire       pull_scl_in,  // peer drives clock zero
  input  wire       pull_sda_in,  // peer drives data zero
  input  wire [3:0] stretch_in,   // link clocks of stretch
  output wire       scl_out,      // wired clock level
  output wire       sda_out       // wired data level
);
  reg [3:0] hold_cnt = 4'h0;
  // a slow slave keeps the clock low a while after the dut lets go
  always @(posedge link_clk_in or posedge scl_oe_in) begin
    if (scl_oe_in) hold_cnt <= stretch_in;
    else if (hold_cnt != 4'h0) hold_cnt <= hold_cnt - 4'h1;
  end
  // pull-ups: a released line floats high, never keeps an old value
  assign scl_out = ~(scl_oe_in | pull_scl_in | (hold_cnt != 4'h0));
  assign sda_out = ~(sda_oe_in | pull_sda_in);
endmodule // tcm_bus_peer

/* File: tcm_ctrl_properties.sv */
`timescale 1ns/1ps
// ==========================================================
// port checks of the control block
module tcm_ctrl_checker (
  input wire        clock_in,    // clock
  input wire        rstn_in,     // reset
  input wire        wb_cyc_in,   // cycle
  input wire        wb_stb_in,   // strobe
  input wire        wb_we_in,    // write
  input wire [7:0]  wb_adr_in,   // address
  input wire [3:0]  wb_sel_in,   // lanes
  input wire [31:0] wb_dat_in,   // wdata
  input wire [31:0] wb_dat_out,  // rdata
  input wire        wb_ack_out,  // ack
  input wire        scl_in,      // clock line
  input wire        scl_out,     // clock value
  input wire        scl_oe_out,  // clock pull
  input wire        sda_in,      // data line
  input wire        sda_out,     // data value
  input wire        sda_oe_out,  // data pull
  input wire        irq_out      // interrupt
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  wire req = wb_cyc_in & wb_stb_in;
  // stop phase: clock released and seen high, data still held
  sequence s_scl_up;
    (!scl_oe_out && sda_oe_out && scl_in) [*6];
  endsequence
  // someone else pulls the clock low in that phase; the sync lag is in the consequent
  sequence s_scl_pulled;
    !scl_oe_out && sda_oe_out && !scl_in;
  endsequence
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (req && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered");
  a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(req))
    else $error("ack without request");
  a_lines_zero: assert property (!scl_out && !sda_out)
    else $error("open drain value not zero");
  a_scl_after_sda: assert property ($fell(scl_oe_out) && $past(sda_oe_out)
    |-> sda_oe_out)
    else $error("clock released before data held");
  a_stop_count: assert property ($rose(scl_in) && !scl_oe_out && sda_oe_out |=> sda_oe_out[*3])
    else $error("data released without count");
  a_stop_collide: assert property (s_scl_up ##1 s_scl_pulled |-> ##[0:8]
    (!sda_oe_out && !scl_oe_out))
    else $error("clock collision not handled");
  a_drive_cause: assert property ($rose(sda_oe_out) |-> wb_ack_out || $past(wb_ack_out)
    || $past(wb_ack_out, 2))
    else $error("line driven without request");
endmodule // tcm_ctrl_checker

bind tcm_ctrl tcm_ctrl_checker u_chk (.clock_in, .rstn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
  .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .scl_in, .scl_out,
  .scl_oe_out, .sda_in, .sda_out, .sda_oe_out, .irq_out);

/* File: tb_tcm_ctrl.sv */
`timescale 1ns/1ps
`include "tcm_defines.vh"
module tb_tcm_ctrl;
  reg         clock_in = 1'b0;
  reg         rstn_in = 1'b0;
  reg         link_clk = 1'b0;
  reg         wb_cyc_in = 1'b0;
  reg         wb_stb_in = 1'b0;
  reg         wb_we_in = 1'b0;
  reg  [7:0]  wb_adr_in = 8'h00;
  reg  [3:0]  wb_sel_in = 4'h1;
  reg  [31:0] wb_dat_in = 32'h0;
  reg         pull_scl = 1'b0;
  reg         pull_sda = 1'b0;
  reg  [3:0]  stretch = 4'h0;
  wire [31:0] wb_dat_out;
  wire        wb_ack_out, scl_in, sda_in, scl_out, sda_out, scl_oe_out, sda_oe_out, irq_out;
  integer     error_cnt = 0;
  integer     num_checks = 0;
  integer     cyc_cnt = 0;
  integer     busy = 0;
  integer     i;
  integer     j;
  reg  [7:0]  mdl [0:7];
  reg  [31:0] q;
  tcm_ctrl u_tcm_ctrl (.clock_in, .rstn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .scl_in, .scl_out, .scl_oe_out,
    .sda_in, .sda_out, .sda_oe_out, .irq_out);
  tcm_bus_peer u_tcm_bus_peer (.link_clk_in(link_clk), .scl_oe_in(scl_oe_out),
    .sda_oe_in(sda_oe_out), .pull_scl_in(pull_scl), .pull_sda_in(pull_sda),
    .stretch_in(stretch), .scl_out(scl_in), .sda_out(sda_in));
  // ==========================================================
  // clocks, the peer clock runs at one sixteenth of the system clock with a fixed phase offset
  always #2 clock_in = ~clock_in;
  initial begin
    #5;
    forever #32 link_clk = ~link_clk;
  end
  // a hang ends the run as a failure
  always @(posedge clock_in) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end
  // ==========================================================
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task wb(input [7:0] a, input w, input [7:0] d);
    integer n;
    begin
      n = 0;
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_dat_in <= {24'h0, d};
      @(posedge clock_in);
      while (wb_ack_out !== 1'b1 && n < 50) begin
        @(posedge clock_in);
        n = n + 1;
      end
      if (n == 50) chk(32'h0, 32'h1);
      q = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge clock_in);
    end
  endtask
  // model: buffer and requests dropped while busy, status is write-one-clear
  task wr(input [7:0] a, input [7:0] d);
    begin
      wb(a, 1'b1, d);
      if (a == `TCM_ADDR_IRQ_STAT) mdl[a[4:2]] = mdl[a[4:2]] & ~d;
      else if (a == `TCM_ADDR_BAUD) mdl[a[4:2]] = d & 8'h7F;
      else if (a == `TCM_ADDR_CTRL2) mdl[0] = busy ? {d[7], mdl[0][6], d[5], mdl[0][4:0]} :
        {d[7], mdl[0][6], d[5:0]};
      else if (a < 8'h1C && !(busy && a == `TCM_ADDR_BUF)) mdl[a[4:2]] = d;
    end
  endtask
  task rd(input [7:0] a);
    begin
      wb(a, 1'b0, 8'h00);
      chk(q, {24'h0, (a < 8'h1C) ? mdl[a[4:2]] : 8'h00});
    end
  endtask
  // run a stop and wait for the event bit it ends with
  task stop_run(input [7:0] baud, input [7:0] ev);
    begin
      wr(`TCM_ADDR_BAUD, baud);
      wr(`TCM_ADDR_CTRL2, 8'h04);
      busy = 1;
      wr(`TCM_ADDR_CTRL2, 8'h01);
      wr(`TCM_ADDR_BUF, 8'h5A);
      q = 32'h0;
      for (i = 0; i < 400 && q[7:0] == 8'h00; i = i + 1) wb(`TCM_ADDR_IRQ_STAT, 1'b0, 8'h00);
      busy = 0;
      mdl[0] = 8'h00;
      mdl[4] = ev;
      chk(q, {24'h0, ev});
      chk({30'h0, scl_oe_out, sda_oe_out}, 32'h0);
      rd(`TCM_ADDR_CTRL2);
      rd(`TCM_ADDR_BUF);
    end
  endtask
  // ==========================================================
  initial begin
    for (i = 0; i < 8; i = i + 1) mdl[i] = 8'h00;
    mdl[2] = 8'h04;
    q = $urandom(79);
    repeat (3) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    // reset values and the unmapped place
    rd(`TCM_ADDR_CTRL2);
    rd(`TCM_ADDR_BAUD);
    rd(`TCM_ADDR_IRQ_MASK);
    wr(8'h1C, 8'hFF);
    rd(8'h1C);
    wr(`TCM_ADDR_BUF, 8'hA5);
    rd(`TCM_ADDR_BUF);
    $display("test 1 done");
    // plain stop, slow slave stretching, random count
    wr(`TCM_ADDR_IRQ_MASK, 8'h07);
    stretch <= 4'h3;
    stop_run(8'h08 + ($urandom % 32), 8'h04);
    chk({31'h0, irq_out}, 32'h1);
    wr(`TCM_ADDR_IRQ_STAT, 8'h04);
    rd(`TCM_ADDR_IRQ_STAT);
    chk({31'h0, irq_out}, 32'h0);
    $display("test 2 done");
    // data held low by another master, interrupt masked
    wr(`TCM_ADDR_IRQ_MASK, 8'h00);
    stretch <= 4'h0;
    pull_sda <= 1'b1;
    stop_run(8'h10, 8'h02);
    chk({31'h0, irq_out}, 32'h0);
    pull_sda <= 1'b0;
    wr(`TCM_ADDR_IRQ_MASK, 8'h02);
    chk({31'h0, irq_out}, 32'h1);
    wr(`TCM_ADDR_IRQ_STAT, 8'h02);
    chk({31'h0, irq_out}, 32'h0);
    $display("test 3 done");
    // clock pulled low during the count before data release
    fork
      stop_run(8'h7F, 8'h02);
      begin
        for (j = 0; j < 100 && scl_oe_out !== 1'b1; j = j + 1) @(posedge clock_in);
        for (j = 0; j < 100 && scl_oe_out !== 1'b0; j = j + 1) @(posedge clock_in);
        repeat (30) @(posedge clock_in);
        pull_scl <= 1'b1;
      end
    join
    pull_scl <= 1'b0;
    chk({31'h0, irq_out}, 32'h1);
    $display("test 4 done");
    // master receive: ack sequence holds data low under one clock, then clears itself
    wr(`TCM_ADDR_MODE, 8'h02);
    wr(`TCM_ADDR_BAUD, 8'h08);
    wr(`TCM_ADDR_CTRL2, 8'h10);
    chk({30'h0, scl_oe_out, sda_oe_out}, 32'h3);
    while (scl_oe_out !== 1'b0) @(posedge clock_in);
    chk({31'h0, sda_oe_out}, 32'h1);
    q = 32'h0;
    while (q[2] !== 1'b1) wb(`TCM_ADDR_IRQ_STAT, 1'b0, 8'h00);
    mdl[0] = 8'h00;
    mdl[4] = mdl[4] | 8'h04;
    chk(q, {24'h0, mdl[4]});
    rd(`TCM_ADDR_CTRL2);
    chk({30'h0, scl_oe_out, sda_oe_out}, 32'h0);
    $display("test 5 done");
    // slave mode: another master clocks in an all-zero byte, general call enabled
    wr(`TCM_ADDR_MODE, 8'h01);
    wr(`TCM_ADDR_CTRL2, 8'h80);
    wr(`TCM_ADDR_IRQ_MASK, 8'h01);
    pull_sda <= 1'b1;
    for (j = 0; j < 19; j = j + 1) begin
      pull_scl <= !j[0];
      repeat (12) @(posedge clock_in);
    end
    chk({31'h0, irq_out}, 32'h1);
    mdl[4] = mdl[4] | 8'h01;
    rd(`TCM_ADDR_IRQ_STAT);
    $display("test 6 done");
    test_done;
  end
endmodule // tb_tcm_ctrl
